/* trig_pkg.sv */
/*
  Constants and types shared by the camera trigger generator.
  Assumes a 200 MHz core clock; period and phase counts are in core clock cycles.
*/
package trig_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

  // ---------------------------------------------------------------
  // Frequency range of the primary trigger
  // ---------------------------------------------------------------
  localparam int unsigned FREQ_MIN_HZ = 6;
  localparam int unsigned FREQ_MAX_HZ = 50;
  localparam int unsigned FREQ_W = 6;
  localparam int unsigned WIDTH_W = 8;   // Pulse widths and offset in ms
  localparam int unsigned PER_W = 26;    // Holds 200e6/6 cycles
  localparam int unsigned TS_W = 64;     // Timestamp in microseconds

  localparam logic [FREQ_W-1:0] FREQ_RST = 6'h1E;
  localparam logic [PER_W-1:0] PER_ZERO = 26'h000_0000;
  localparam logic [TS_W-1:0] TS_ZERO = 64'h0000_0000_0000_0000;

  // ---------------------------------------------------------------
  // Period sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_RELOAD = 2'b11
  } seq_state_type;

endpackage

/* pulse_if.sv */
/*
  Carrier between the period sequencer and the pulse slicer.
  Assumes one clock domain; the sequencer drives phase and window, the slicer drives pulse.
*/
`timescale 1ns/100ps
interface pulse_if;
  import trig_pkg::*;
  logic [PER_W-1:0] phase;
  logic [PER_W-1:0] start;
  logic [PER_W-1:0] len;
  logic run;
  logic pulse;

  modport seq (output phase, output start, output len, output run, input pulse);
  modport slice (input phase, input start, input len, input run, output pulse);
endinterface

/* pulse_slicer.sv */
/*
  Pulse slicer: drives a registered high level while the period phase lies
  inside the window [start, start+len). Assumes start+len fits the period.
*/
`timescale 1ns/100ps
module pulse_slicer
(
  input wire logic mclk,      // Core clock
  input wire logic reset_n,   // Async reset, active low
  pulse_if.slice pi           // Phase and window
);
  import trig_pkg::*;

  logic [PER_W:0] stop;
  logic pulse_r;

  assign stop = {1'b0, pi.start} + {1'b0, pi.len};

  // ---------------------------------------------------------------
  // Active-high window
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pulse_r <= 1'b0;
    else
      pulse_r <= pi.run && (pi.len != PER_ZERO) && (pi.phase >= pi.start)
                 && ({1'b0, pi.phase} < stop);
  end

  assign pi.pulse = pulse_r;
endmodule

/* camera_trigger_pulse_generator.sv */
/*
  Two-output camera trigger generator with frame timestamping and PPS reset.
  Assumes configuration inputs are static or change between periods, and
  that the PPS input is synchronous to mclk and high for at least one cycle.
*/
`timescale 1ns/100ps
// Function
// - Each trigger output has its own enable; a disabled output stays low.
// - Primary trigger repeats at a configurable rate from 6 to 50 Hz.
// - Primary pulse width is set in milliseconds and holds every period.
// - Trigger pulses are active high, low for the rest of the period.
// - With trigger-time option, frame timestamp is the primary trigger time.
// - Secondary trigger may be active only while primary is enabled.
// - Secondary trigger always uses the primary repetition frequency.
// - Secondary rising edge follows primary rising edge by a configured offset.
// - Secondary trigger has its own pulse width.
// - With PPS sync enabled the secondary output is unavailable.
// - With PPS sync, each PPS pulse resets the internal clock to zero.
// - Frame timestamps come from the internal clock.
module camera_trigger_pulse_generator
#(
  parameter int unsigned CLK_HZ_P = trig_pkg::CLK_HZ // Core clock rate
)
(
  input wire logic mclk,                            // Core clock, 200 MHz
  input wire logic reset_n,                         // Async reset, active low
  input wire logic trig0_en,                        // Primary trigger enable
  input wire logic trig1_en,                        // Secondary trigger enable
  input wire logic [trig_pkg::FREQ_W-1:0] freq_hz,  // Primary rate, Hz
  input wire logic [trig_pkg::WIDTH_W-1:0] width0_ms, // Primary width, ms
  input wire logic [trig_pkg::WIDTH_W-1:0] width1_ms, // Secondary width, ms
  input wire logic [trig_pkg::WIDTH_W-1:0] offset1_ms, // Secondary offset, ms
  input wire logic pps_en,                          // PPS sync enable
  input wire logic ts_trig_sel,                     // Timestamp at trigger
  input wire logic frame_done,                      // Frame captured strobe
  input wire logic pps_in,                          // Shared pin, input side
  output logic pps_pin_o,                           // Shared pin, output
  output logic pps_pin_oe,                          // Shared pin drive enable
  output logic trig0_o,                             // Primary trigger pin
  output logic [trig_pkg::TS_W-1:0] time_us,        // Internal clock, us
  output logic [trig_pkg::TS_W-1:0] frame_ts,       // Timestamp of last frame
  output logic frame_ts_vld                         // Frame timestamp strobe
);
  import trig_pkg::*;

  localparam logic [PER_W-1:0] CYC_MS = PER_W'(CLK_HZ_P / MS_PER_S);
  localparam logic [PER_W-1:0] PER_ONE = 26'h000_0001;
  // Below 1 MHz the clock ticks once per cycle; a zero divider would freeze it
  localparam logic [PER_W-1:0] CYC_US = (CLK_HZ_P >= US_PER_S) ?
    PER_W'(CLK_HZ_P / US_PER_S) : PER_ONE;
  localparam logic [TS_W-1:0] TS_ONE = 64'h0000_0000_0000_0001;

  pulse_if p0 ();
  pulse_if p1 ();

  seq_state_type state_r, state_nxt;
  logic [FREQ_W-1:0] freq_clip;
  logic [PER_W-1:0] period_r;
  logic [PER_W-1:0] phase_r;
  logic [PER_W-1:0] len0, len1, start1, max_len;
  logic [PER_W-1:0] w0_cyc, w1_cyc, off_cyc;
  logic [PER_W-1:0] us_cnt_r;
  logic [TS_W-1:0] time_r;
  logic [TS_W-1:0] trig_ts_r;
  logic [TS_W-1:0] frame_ts_r;
  logic frame_ts_vld_r;
  logic pps_d_r;
  logic pps_rise;
  logic sec_ok;

  // ---------------------------------------------------------------
  // Period from frequency
  // ---------------------------------------------------------------
  always_comb
  begin
    if (freq_hz < FREQ_W'(FREQ_MIN_HZ))
      freq_clip = FREQ_W'(FREQ_MIN_HZ);
    else if (freq_hz > FREQ_W'(FREQ_MAX_HZ))
      freq_clip = FREQ_W'(FREQ_MAX_HZ);
    else
      freq_clip = freq_hz;
  end

  // Divider is registered only outside ST_RUN; rate changes apply after the primary is disabled and re-enabled
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      period_r <= PER_ZERO;
    else if (state_r != ST_RUN)
      period_r <= PER_W'(CLK_HZ_P / 32'(freq_clip));
  end

  // ---------------------------------------------------------------
  // Widths and offset, clipped inside the period
  // ---------------------------------------------------------------
  assign w0_cyc = PER_W'(32'(width0_ms) * 32'(CYC_MS));
  assign w1_cyc = PER_W'(32'(width1_ms) * 32'(CYC_MS));
  assign off_cyc = PER_W'(32'(offset1_ms) * 32'(CYC_MS));
  assign max_len = period_r - PER_ONE;

  always_comb
  begin
    len0 = (w0_cyc > max_len) ? max_len : w0_cyc;
    start1 = (off_cyc > max_len) ? max_len : off_cyc;
    len1 = (w1_cyc > max_len - start1) ? max_len - start1 : w1_cyc;
  end

  // ---------------------------------------------------------------
  // Period sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    case (state_r)
      ST_IDLE: state_nxt = trig0_en ? ST_RELOAD : ST_IDLE;
      ST_RELOAD: state_nxt = trig0_en ? ST_RUN : ST_IDLE;
      ST_RUN:
      begin
        if (!trig0_en)
          state_nxt = ST_IDLE;
        else
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Shared phase keeps both triggers on one period
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      phase_r <= PER_ZERO;
    else if (state_r != ST_RUN || phase_r >= max_len)
      phase_r <= PER_ZERO;
    else
      phase_r <= phase_r + PER_ONE;
  end

  // ---------------------------------------------------------------
  // Slicers
  // ---------------------------------------------------------------
  assign sec_ok = trig0_en && trig1_en && !pps_en;

  assign p0.phase = phase_r;
  assign p0.start = PER_ZERO;
  assign p0.len = len0;
  assign p0.run = (state_r == ST_RUN) && trig0_en;

  assign p1.phase = phase_r;
  assign p1.start = start1;
  assign p1.len = len1;
  assign p1.run = (state_r == ST_RUN) && sec_ok;

  pulse_slicer u_slice0
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .pi(p0)
  );

  pulse_slicer u_slice1
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .pi(p1)
  );

  assign trig0_o = p0.pulse;
  assign pps_pin_o = p1.pulse;
  assign pps_pin_oe = !pps_en;

  // ---------------------------------------------------------------
  // Internal clock with PPS reset
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pps_d_r <= 1'b0;
    else
      pps_d_r <= pps_in;
  end

  assign pps_rise = pps_en && pps_in && !pps_d_r;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      us_cnt_r <= PER_ZERO;
    else if (pps_rise || us_cnt_r >= CYC_US - PER_ONE)
      us_cnt_r <= PER_ZERO;
    else
      us_cnt_r <= us_cnt_r + PER_ONE;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      time_r <= TS_ZERO;
    else if (pps_rise)
      time_r <= TS_ZERO;
    else if (us_cnt_r >= CYC_US - PER_ONE)
      time_r <= time_r + TS_ONE;
  end

  assign time_us = time_r;

  // ---------------------------------------------------------------
  // Timestamps
  // ---------------------------------------------------------------
  // Captured at the primary rising edge; relies on cameras never skipping
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      trig_ts_r <= TS_ZERO;
    else if (p0.run && phase_r == PER_ZERO && len0 != PER_ZERO)
      trig_ts_r <= time_r;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_ts_r <= TS_ZERO;
      frame_ts_vld_r <= 1'b0;
    end
    else
    begin
      frame_ts_vld_r <= frame_done;
      if (frame_done)
        frame_ts_r <= ts_trig_sel ? trig_ts_r : time_r;
    end
  end

  assign frame_ts = frame_ts_r;
  assign frame_ts_vld = frame_ts_vld_r;
endmodule

/* trig_assertions.sv */
/* Port checker for the camera trigger generator.
   Assumes the core clock and active-low reset of the top module. */
`timescale 1ns/100ps
module trig_assertions
(
  input wire logic mclk, // Core clock
  input wire logic reset_n, // Reset, active low
  input wire logic trig0_en, // Primary enable
  input wire logic trig1_en, // Secondary enable
  input wire logic pps_en, // PPS sync enable
  input wire logic [trig_pkg::WIDTH_W-1:0] width0_ms, // Primary width
  input wire logic frame_done, // Capture strobe
  input wire logic pps_in, // Shared pin level
  input wire logic pps_pin_o, // Secondary trigger
  input wire logic pps_pin_oe, // Shared pin drive
  input wire logic trig0_o, // Primary trigger
  input wire logic [trig_pkg::TS_W-1:0] time_us, // Internal clock
  input wire logic frame_ts_vld // Stamp strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_off0; !trig0_en [*3] |-> !trig0_o; endproperty
  a_off0: assert property (p_off0) else $error("primary high while disabled");
  property p_off1; (!trig0_en || !trig1_en || pps_en) [*3] |-> !pps_pin_o; endproperty
  a_off1: assert property (p_off1) else $error("secondary high while barred");
  property p_oe; pps_pin_oe == !pps_en; endproperty
  a_oe: assert property (p_oe) else $error("shared pin drive wrong");
  property p_pps; pps_en && $rose(pps_in) |=> time_us == '0; endproperty
  a_pps: assert property (p_pps) else $error("clock not cleared");
  property p_tick; $changed(time_us) |-> time_us == $past(time_us) + 1 || time_us == '0;
  endproperty
  a_tick: assert property (p_tick) else $error("clock jumped");
  property p_vld; frame_done |=> frame_ts_vld; endproperty
  a_vld: assert property (p_vld) else $error("frame stamp missing");
  property p_vsrc; frame_ts_vld |-> $past(frame_done); endproperty
  a_vsrc: assert property (p_vsrc) else $error("stray frame stamp");
  property p_w0;
    $rose(trig0_o) && width0_ms != 0 |=> (trig0_o || !$past(trig0_en)) [*7];
  endproperty
  a_w0: assert property (p_w0) else $error("primary pulse cut short");
  c_t0: cover property ($rose(trig0_o));
  c_t1: cover property ($rose(pps_pin_o));
  c_fs: cover property (frame_ts_vld);
endmodule
bind camera_trigger_pulse_generator trig_assertions chk (.mclk, .reset_n, .trig0_en,
  .trig1_en, .pps_en, .width0_ms, .frame_done, .pps_in, .pps_pin_o, .pps_pin_oe,
  .trig0_o, .time_us, .frame_ts_vld);

/* cam_model.sv */
/* Camera model: captures one frame a few cycles after each trigger rise.
   Assumes triggers are far apart compared with the capture delay. */
`timescale 1ns/100ps
module cam_model #(parameter int DLY = 3)
(
  input wire logic mclk, // Core clock
  input wire logic reset_n, // Reset, active low
  input wire logic trig, // Trigger line
  output logic frame_done, // Capture strobe
  output int frames // Frames captured
);
  logic trig_r;
  int cnt;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trig_r <= 1'b0;
      cnt <= 0;
      frame_done <= 1'b0;
      frames <= 0;
    end
    else
    begin
      trig_r <= trig;
      frame_done <= cnt == 1;
      cnt <= (trig && !trig_r) ? DLY : (cnt > 0 ? cnt - 1 : 0);
      frames <= frames + (cnt == 1 ? 1 : 0);
    end
  end
endmodule

/* camera_trigger_pulse_generator_tb_top.sv */
/* Self-checking bench for the camera trigger generator.
   Assumes a shortened clock rate parameter so periods stay short. */
`timescale 1ns/100ps
module camera_trigger_pulse_generator_tb_top;
  import trig_pkg::*;
  localparam int HZ = 20000;
  localparam int CMS = HZ / 1000;
  logic mclk = 0, reset_n = 0, trig0_en = 0, trig1_en = 0, pps_en = 0, ts_trig_sel = 0;
  logic pps_src = 0, t0q = 0, t1q = 0;
  logic [FREQ_W-1:0] freq_hz = FREQ_RST;
  logic [WIDTH_W-1:0] width0_ms = 8'h01, width1_ms = 8'h01, offset1_ms = 8'h01;
  logic frame_done, pps_pin_o, pps_pin_oe, trig0_o, frame_ts_vld, pps_in;
  logic [TS_W-1:0] time_us, frame_ts, t_rise;
  int cyc = 0, rp = 0, rl = 0, r1 = 0, n0 = 0, n1 = 0, nv = 0, w0m = 0, w1m = 0, om = 0;
  int err_total = 0, checked = 0, frames;
  integer seed = 32'h283e;
  // Released pin falls back to the PPS source
  assign pps_in = pps_pin_oe ? pps_pin_o : pps_src;
  always #2.5 mclk = ~mclk;
  camera_trigger_pulse_generator #(.CLK_HZ_P(HZ)) dut (.mclk(mclk), .reset_n(reset_n),
    .trig0_en(trig0_en), .trig1_en(trig1_en), .freq_hz(freq_hz), .width0_ms(width0_ms),
    .width1_ms(width1_ms), .offset1_ms(offset1_ms), .pps_en(pps_en),
    .ts_trig_sel(ts_trig_sel), .frame_done(frame_done), .pps_in(pps_in),
    .pps_pin_o(pps_pin_o), .pps_pin_oe(pps_pin_oe), .trig0_o(trig0_o), .time_us(time_us),
    .frame_ts(frame_ts), .frame_ts_vld(frame_ts_vld));
  cam_model cam (.mclk(mclk), .reset_n(reset_n), .trig(trig0_o), .frame_done(frame_done),
    .frames(frames));
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic int exp_per(input int f);
    int c = f < FREQ_MIN_HZ ? FREQ_MIN_HZ : (f > FREQ_MAX_HZ ? FREQ_MAX_HZ : f);
    return HZ / c;
  endfunction
  // Edge times in cycles; every edge is seen one cycle late, so differences are exact
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      chk(1'b0, "timeout");
      final_report();
    end
    if (trig0_o && !t0q)
    begin
      rp <= rl;
      rl <= cyc;
      n0 <= n0 + 1;
      t_rise <= time_us;
    end
    if (!trig0_o && t0q)
      w0m <= cyc - rl;
    if (pps_pin_o && !t1q)
    begin
      r1 <= cyc;
      om <= cyc - rl;
      n1 <= n1 + 1;
    end
    if (!pps_pin_o && t1q)
      w1m <= cyc - r1;
    if (frame_ts_vld)
      nv <= nv + 1;
    if (frame_ts_vld && ts_trig_sel)
      chk(frame_ts <= t_rise && frame_ts + 2 >= t_rise, "frame stamp");
    t0q <= trig0_o;
    t1q <= pps_pin_o;
  end
  task automatic run(input int f, w0, w1, o, input bit e1, pe);
    int s1;
    @(posedge mclk);
    trig0_en <= 1'b0;
    freq_hz <= f[FREQ_W-1:0];
    width0_ms <= w0[WIDTH_W-1:0];
    width1_ms <= w1[WIDTH_W-1:0];
    offset1_ms <= o[WIDTH_W-1:0];
    trig1_en <= e1;
    pps_en <= pe;
    ts_trig_sel <= !pe;
    repeat (2) @(posedge mclk);
    trig0_en <= 1'b1;
    s1 = n0;
    wait (n0 == s1 + 4);
    repeat (8) @(posedge mclk);
    chk(rl - rp == exp_per(f), "period");
    chk(w0m == w0 * CMS, "primary width");
    if (e1 && !pe)
      chk(om == o * CMS && w1m == w1 * CMS, "secondary timing");
    chk(pps_pin_oe === !pe && (e1 && !pe || !pps_pin_o), "pin use");
    chk(frames == n0 && nv == n0, "frame count");
    if (pe)
    begin
      pps_src <= 1'b1;
      @(posedge mclk);
      pps_src <= 1'b0;
      #1 chk(time_us === TS_ZERO, "pps clear");
    end
    $display("test f=%0d w0=%0d w1=%0d o=%0d done", f, w0, w1, o);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    chk(trig0_o === 1'b0 && time_us === TS_ZERO, "reset state");
    reset_n <= 1'b1;
    run(50, 3, 2, 4, 1, 0);
    run(6, 1, 1, 1, 1, 0);
    run(60, 2, 1, 1, 1, 0);
    run(50, 1, 1, 1, 0, 0);
    run(50, 1, 1, 1, 1, 1);
    for (int k = 0; k < 2; k++)
      run(6 + ($random(seed) & 31), 1 + ($random(seed) & 3), 1 + ($random(seed) & 3),
        1 + ($random(seed) & 3), 1, 0);
    trig0_en <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk(trig0_o === 1'b0 && pps_pin_o === 1'b0, "disabled outputs");
    final_report();
  end
endmodule
